// file: logic/tmc_pkg.sv
// constants, register map and state codes of the master control/status block
// assumes a 125 MHz system clock and a 16-bit host register port
package tmc_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int IRQ_PULSE_NS = 1000;
    localparam int IRQ_PULSE_CYC = IRQ_PULSE_NS / CLK_PERIOD_NS;
    localparam int ACK_MIN_NS = 250;
    localparam int ACK_MIN_CYC = (ACK_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam logic [6:0] PULSE_LAST = 7'(IRQ_PULSE_CYC - 1);
    localparam logic [5:0] ACK_LAST = 6'(ACK_MIN_CYC - 1);

    // register addresses (word addresses on the host port)
    localparam logic [15:0] ADDR_MCFG = 16'h0000;
    localparam logic [15:0] ADDR_MSTAT = 16'h0001;
    localparam logic [15:0] ADDR_PEND_IRQ = 16'h0006;
    localparam logic [15:0] RT_BASE = 16'h0010;
    localparam logic [15:0] RT_STRIDE = 16'h0010;
    localparam logic [3:0] OFF_RTCFG = 4'h0;
    localparam logic [3:0] OFF_SEL_A = 4'h1;
    localparam logic [3:0] OFF_SEL_B = 4'h2;
    localparam logic [3:0] OFF_BITW = 4'h3;

    // master configuration fields
    localparam int CFG_TXO_BIT = 3;
    localparam int CFG_IRQ_LEVEL_SELECT_BIT = 2;
    localparam int CFG_MONITOR_ACTIVITY_INCLUDE_BIT = 1;
    localparam logic [3:0] MCFG_RESET = 4'h0;

    // master status and reset fields
    localparam int ST_READY_BIT = 15;
    localparam int ST_AUTO_INIT_ENABLE_BIT = 13;
    localparam int ST_MTRST_BIT = 12;
    localparam int ST_RT2RST_BIT = 11;
    localparam int ST_RT1RST_BIT = 10;
    localparam logic [15:0] MSTAT_RESET = 16'h0000;

    // terminal configuration fields
    localparam int RTC_INH_A_BIT = 0;
    localparam int RTC_INH_B_BIT = 1;
    localparam int RTC_AUTO_BIT = 2;
    localparam logic [2:0] RTC_RESET = 3'h0;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam int BITW_SHUT_LSB = 12;

    // mode codes handled automatically
    localparam logic [4:0] MC_SEL_SHUTDOWN = 5'h14;
    localparam logic [4:0] MC_OVR_SEL_SHUTDOWN = 5'h15;

    typedef enum logic [1:0] {
        TMC_IRQ_IDLE = 2'b00,
        TMC_IRQ_PULSE = 2'b01,
        TMC_IRQ_LEVEL = 2'b10
    } tmc_irq_st_t;
endpackage

// file: logic/tmc_irq_gen.sv
// interrupt request output: pulsed or held-level active-low request
// assumes events are one-cycle pulses synchronous to i_mclk
`timescale 1ns/1ns
module tmc_irq_gen (
    input logic i_mclk,        // system clock
    input logic i_rst,         // async reset, active high
    input logic i_level_sel,   // 1 = level request, 0 = pulse
    input logic i_event,       // enabled interrupt event pulse
    input logic i_ack,         // acknowledge input level
    input logic i_pend_read,   // host read of pending interrupt register
    output logic o_irq_n       // interrupt request, active low
);
    tmc_pkg::tmc_irq_st_t st_ff, nxt_st;
    logic [6:0] cnt_ff, nxt_cnt;
    logic [5:0] ack_ff, nxt_ack;
    logic irq_n_ff, nxt_irq_n;
    logic release_req;

    always_comb begin
        nxt_ack = 6'h00;
        if (i_ack) begin
            nxt_ack = (ack_ff == tmc_pkg::ACK_LAST) ? ack_ff : ack_ff + 6'h01;
        end
        release_req = i_pend_read || (i_ack && ack_ff == tmc_pkg::ACK_LAST);
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_irq_n = irq_n_ff;
        case (st_ff)
            tmc_pkg::TMC_IRQ_IDLE: begin
                if (i_event) begin
                    nxt_irq_n = 1'b0;
                    nxt_cnt = 7'h00;
                    nxt_st = i_level_sel ? tmc_pkg::TMC_IRQ_LEVEL
                                         : tmc_pkg::TMC_IRQ_PULSE;
                end
            end
            tmc_pkg::TMC_IRQ_PULSE: begin
                if (cnt_ff == tmc_pkg::PULSE_LAST) begin
                    nxt_st = tmc_pkg::TMC_IRQ_IDLE;
                    nxt_irq_n = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff + 7'h01;
                end
            end
            tmc_pkg::TMC_IRQ_LEVEL: begin
                // a new event in the release cycle keeps the request low
                if (release_req && !i_event) begin
                    nxt_st = tmc_pkg::TMC_IRQ_IDLE;
                    nxt_irq_n = 1'b1;
                end
            end
            default: begin
                nxt_st = tmc_pkg::TMC_IRQ_IDLE;
                nxt_irq_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= tmc_pkg::TMC_IRQ_IDLE;
            cnt_ff <= 7'h00;
            ack_ff <= 6'h00;
            irq_n_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ack_ff <= nxt_ack;
            irq_n_ff <= nxt_irq_n;
        end
    end

    assign o_irq_n = irq_n_ff;

    a_pulse_width: assert property (@(posedge i_mclk) disable iff (i_rst)
        ($fell(irq_n_ff) && st_ff == tmc_pkg::TMC_IRQ_PULSE)
        |-> ##125 $rose(irq_n_ff))
        else $error("irq pulse not 125 cycles");
    a_pulse_low: assert property (@(posedge i_mclk) disable iff (i_rst)
        st_ff == tmc_pkg::TMC_IRQ_PULSE |-> !irq_n_ff)
        else $error("irq high during pulse");
    a_level_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        (st_ff == tmc_pkg::TMC_IRQ_LEVEL && !i_ack && !i_pend_read)
        |=> !irq_n_ff)
        else $error("level irq released without host action");
    a_ack_release: assert property (@(posedge i_mclk) disable iff (i_rst)
        (st_ff == tmc_pkg::TMC_IRQ_LEVEL && i_ack && !i_event
         && ack_ff == tmc_pkg::ACK_LAST) |=> irq_n_ff)
        else $error("held ack did not release irq");
endmodule

// file: logic/tmc_top.sv
// master control and status of a multi-terminal 1553 device
// assumes a synchronous host register port and terminal cores that report
// mode codes, activity and reset completion as signals on i_mclk
`timescale 1ns/1ns
module tmc_top (
    input logic i_mclk,                 // system clock, 125 MHz
    input logic i_rst,                  // master reset, async, active high
    input logic i_host_rd,              // host read strobe
    input logic i_host_wr,              // host write strobe
    input logic [15:0] i_host_addr,     // host register address
    input logic [15:0] i_host_wdata,    // host write data
    output logic [15:0] o_host_rdata,   // host read data
    output logic o_host_rvalid,         // read data valid pulse
    input logic i_auto_init_enable,     // auto-init strap pin
    input logic i_auto_init_busy,       // auto-initialization running
    input logic i_bist_busy,            // built-in test running
    input logic i_mt_reset_done,        // monitor reset finished pulse
    input logic [1:0] i_rt_reset_done,  // terminal resets finished pulses
    input logic i_mc_strobe,            // mode code received pulse
    input logic i_mc_rt,                // terminal index of the mode code
    input logic [4:0] i_mc_code,        // mode code number
    input logic [15:0] i_mc_data,       // mode data word
    input logic i_irq_event,            // enabled interrupt event pulse
    input logic i_interrupt_acknowledge_input, // irq acknowledge level
    input logic i_mt_active,            // enabled monitor activity
    input logic i_other_active,         // other on-chip terminal activity
    output logic o_irq_n,               // interrupt request, active low
    output logic o_ready,               // ready pin
    output logic o_active,              // activity pin
    output logic o_mt_reset_req,        // monitor soft reset in progress
    output logic [1:0] o_rt_reset_req,  // terminal soft resets in progress
    output logic [3:0] o_tx_inhibit,    // {rt2 b, rt2 a, rt1 b, rt1 a}
    output logic [3:0] o_rx_inhibit     // same order as o_tx_inhibit
);
    function automatic logic [15:0] rt_addr(input int idx,
                                            input logic [3:0] off);
        rt_addr = 16'(tmc_pkg::RT_BASE + tmc_pkg::RT_STRIDE * idx) +
                  {12'h000, off};
    endfunction

    logic [3:0] mcfg_ff, nxt_mcfg;
    logic ready_ff, nxt_ready;
    logic auto_init_enable_ff, nxt_auto_init_enable;
    logic first_ff;
    logic mtrst_ff, nxt_mtrst;
    logic [1:0] rtrst_ff, nxt_rtrst;
    logic [15:0] stat_word;
    logic [2:0] rtcfg_ff [2];
    logic [2:0] nxt_rtcfg [2];
    logic [15:0] sela_ff [2];
    logic [15:0] nxt_sela [2];
    logic [15:0] selb_ff [2];
    logic [15:0] nxt_selb [2];
    logic [1:0] ashut_ff [2];
    logic [1:0] nxt_ashut [2];
    logic [3:0] tx_inh, rx_inh;
    logic [3:0] tx_ff, rx_ff;
    logic active_ff, nxt_active;
    logic [15:0] rdata_ff, nxt_rdata;
    logic rvalid_ff;
    logic wr_ok, rd_ok, pend_read;

    // host locked out while not ready
    assign wr_ok = i_host_wr && ready_ff;
    assign rd_ok = i_host_rd && ready_ff;
    assign pend_read = rd_ok && i_host_addr == tmc_pkg::ADDR_PEND_IRQ;

    // master configuration
    always_comb begin
        nxt_mcfg = mcfg_ff;
        if (wr_ok && i_host_addr == tmc_pkg::ADDR_MCFG) begin
            nxt_mcfg = {i_host_wdata[3:1], 1'b0};
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mcfg_ff <= tmc_pkg::MCFG_RESET;
        end else begin
            mcfg_ff <= nxt_mcfg;
        end
    end

    // master status and reset
    always_comb begin
        nxt_mtrst = mtrst_ff;
        nxt_rtrst = rtrst_ff;
        if (i_mt_reset_done) begin
            nxt_mtrst = 1'b0;
        end
        nxt_rtrst = rtrst_ff & ~i_rt_reset_done;
        // write of one starts monitor reset, set beats done
        if (wr_ok && i_host_addr == tmc_pkg::ADDR_MSTAT) begin
            nxt_mtrst = nxt_mtrst | i_host_wdata[tmc_pkg::ST_MTRST_BIT];
            nxt_rtrst = nxt_rtrst | {i_host_wdata[tmc_pkg::ST_RT2RST_BIT],
                                     i_host_wdata[tmc_pkg::ST_RT1RST_BIT]};
        end
        // ready low while anything is busy
        nxt_ready = !(nxt_mtrst || (|nxt_rtrst) || i_auto_init_busy ||
                      i_bist_busy);
        // strap taken in the first cycle after reset release
        nxt_auto_init_enable = first_ff ? i_auto_init_enable : auto_init_enable_ff;
        stat_word = tmc_pkg::MSTAT_RESET;
        stat_word[tmc_pkg::ST_READY_BIT] = ready_ff;
        stat_word[tmc_pkg::ST_AUTO_INIT_ENABLE_BIT] = auto_init_enable_ff;
        stat_word[tmc_pkg::ST_MTRST_BIT] = mtrst_ff;
        stat_word[tmc_pkg::ST_RT2RST_BIT] = rtrst_ff[1];
        stat_word[tmc_pkg::ST_RT1RST_BIT] = rtrst_ff[0];
    end

    // auto-init enable cleared by master reset only; soft resets leave it alone
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ready_ff <= 1'b0;
            auto_init_enable_ff <= 1'b0;
            first_ff <= 1'b1;
            mtrst_ff <= 1'b0;
            rtrst_ff <= 2'b00;
        end else begin
            ready_ff <= nxt_ready;
            auto_init_enable_ff <= nxt_auto_init_enable;
            first_ff <= 1'b0;
            mtrst_ff <= nxt_mtrst;
            rtrst_ff <= nxt_rtrst;
        end
    end

    // terminal configuration, select words and automatic shutdown
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            nxt_rtcfg[i] = rtcfg_ff[i];
            nxt_sela[i] = sela_ff[i];
            nxt_selb[i] = selb_ff[i];
            nxt_ashut[i] = ashut_ff[i];
            if (wr_ok && i_host_addr == rt_addr(i, tmc_pkg::OFF_RTCFG)) begin
                nxt_rtcfg[i] = i_host_wdata[2:0];
            end
            if (wr_ok && i_host_addr == rt_addr(i, tmc_pkg::OFF_SEL_A)) begin
                nxt_sela[i] = i_host_wdata;
            end
            if (wr_ok && i_host_addr == rt_addr(i, tmc_pkg::OFF_SEL_B)) begin
                nxt_selb[i] = i_host_wdata;
            end
            // mode codes left to the host when auto is off
            // matching data word shuts down or restores the bus
            if (i_mc_strobe && i_mc_rt == 1'(i) &&
                rtcfg_ff[i][tmc_pkg::RTC_AUTO_BIT]) begin
                if (i_mc_code == tmc_pkg::MC_SEL_SHUTDOWN) begin
                    if (i_mc_data == sela_ff[i]) nxt_ashut[i][0] = 1'b1;
                    if (i_mc_data == selb_ff[i]) nxt_ashut[i][1] = 1'b1;
                end else if (i_mc_code == tmc_pkg::MC_OVR_SEL_SHUTDOWN) begin
                    if (i_mc_data == sela_ff[i]) nxt_ashut[i][0] = 1'b0;
                    if (i_mc_data == selb_ff[i]) nxt_ashut[i][1] = 1'b0;
                end
            end
            // auto shutdown kept apart from the inhibit bits
            tx_inh[2*i] = rtcfg_ff[i][tmc_pkg::RTC_INH_A_BIT] |
                          ashut_ff[i][0];
            tx_inh[2*i+1] = rtcfg_ff[i][tmc_pkg::RTC_INH_B_BIT] |
                            ashut_ff[i][1];
            rx_inh[2*i] = tx_inh[2*i] & ~mcfg_ff[tmc_pkg::CFG_TXO_BIT];
            rx_inh[2*i+1] = tx_inh[2*i+1] & ~mcfg_ff[tmc_pkg::CFG_TXO_BIT];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 2; i++) begin
                rtcfg_ff[i] <= tmc_pkg::RTC_RESET;
                sela_ff[i] <= tmc_pkg::SEL_RESET;
                selb_ff[i] <= tmc_pkg::SEL_RESET;
                ashut_ff[i] <= 2'b00;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                rtcfg_ff[i] <= nxt_rtcfg[i];
                sela_ff[i] <= nxt_sela[i];
                selb_ff[i] <= nxt_selb[i];
                ashut_ff[i] <= nxt_ashut[i];
            end
        end
    end

    // host read data and activity output
    always_comb begin
        nxt_rdata = rdata_ff;
        // any read while not ready returns the status word
        if (i_host_rd && !ready_ff) begin
            nxt_rdata = stat_word;
        end else if (rd_ok) begin
            nxt_rdata = 16'h0000;
            if (i_host_addr == tmc_pkg::ADDR_MCFG) begin
                nxt_rdata = {12'h000, mcfg_ff};
            end
            if (i_host_addr == tmc_pkg::ADDR_MSTAT) begin
                nxt_rdata = stat_word;
            end
            for (int i = 0; i < 2; i++) begin
                if (i_host_addr == rt_addr(i, tmc_pkg::OFF_RTCFG)) begin
                    nxt_rdata = {13'h0000, rtcfg_ff[i]};
                end
                if (i_host_addr == rt_addr(i, tmc_pkg::OFF_SEL_A)) begin
                    nxt_rdata = sela_ff[i];
                end
                if (i_host_addr == rt_addr(i, tmc_pkg::OFF_SEL_B)) begin
                    nxt_rdata = selb_ff[i];
                end
                // shutdown state in the top four bits
                if (i_host_addr == rt_addr(i, tmc_pkg::OFF_BITW)) begin
                    nxt_rdata = {tx_inh[2*i+1], rx_inh[2*i+1], tx_inh[2*i],
                                 rx_inh[2*i], 12'h000};
                end
            end
        end
        nxt_active = i_other_active ||
                     (mcfg_ff[tmc_pkg::CFG_MONITOR_ACTIVITY_INCLUDE_BIT] && i_mt_active);
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
            active_ff <= 1'b0;
            tx_ff <= 4'h0;
            rx_ff <= 4'h0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= i_host_rd;
            active_ff <= nxt_active;
            tx_ff <= tx_inh;
            rx_ff <= rx_inh;
        end
    end

    tmc_irq_gen u_irq (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level_sel(mcfg_ff[tmc_pkg::CFG_IRQ_LEVEL_SELECT_BIT]),
        .i_event(i_irq_event),
        .i_ack(i_interrupt_acknowledge_input),
        .i_pend_read(pend_read),
        .o_irq_n(o_irq_n)
    );

    assign o_host_rdata = rdata_ff;
    assign o_host_rvalid = rvalid_ff;
    assign o_ready = ready_ff;
    assign o_active = active_ff;
    assign o_mt_reset_req = mtrst_ff;
    assign o_rt_reset_req = rtrst_ff;
    assign o_tx_inhibit = tx_ff;
    assign o_rx_inhibit = rx_ff;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_mt_start;
        wr_ok && i_host_addr == tmc_pkg::ADDR_MSTAT &&
            i_host_wdata[tmc_pkg::ST_MTRST_BIT];
    endsequence
    sequence s_mt_busy;
        mtrst_ff && !ready_ff;
    endsequence

    a_mt_reset_start: assert property (s_mt_start |=> s_mt_busy)
        else $error("monitor reset did not start with ready low");
    a_mt_reset_end: assert property ((mtrst_ff && i_mt_reset_done &&
        !(wr_ok && i_host_addr == tmc_pkg::ADDR_MSTAT &&
          i_host_wdata[tmc_pkg::ST_MTRST_BIT]) &&
        !(|rtrst_ff) && !i_auto_init_busy &&
        !i_bist_busy && !(|i_host_wdata[11:10] && wr_ok)) |=>
        !mtrst_ff && ready_ff)
        else $error("monitor reset did not self clear");
    a_ready_busy: assert property ((mtrst_ff || (|rtrst_ff)) |-> !o_ready)
        else $error("ready high during soft reset");
    a_locked_read: assert property ((i_host_rd && !o_ready) |=>
        o_host_rvalid && o_host_rdata == $past(stat_word))
        else $error("locked read did not return status");
    a_cfg_bit0: assert property ((rd_ok &&
        i_host_addr == tmc_pkg::ADDR_MCFG) |=> o_host_rdata[0] == 1'b0)
        else $error("config bit 0 not zero");
    a_stat_rsvd: assert property ((i_host_rd && !o_ready) |=>
        o_host_rdata[14] == 1'b0)
        else $error("status bit 14 not zero");
    a_auto_init_enable_hold: assert property (!first_ff |=> $stable(auto_init_enable_ff))
        else $error("auto-init status changed after reset");
    a_auto_off: assert property ((i_mc_strobe &&
        !rtcfg_ff[i_mc_rt][tmc_pkg::RTC_AUTO_BIT]) |=>
        ashut_ff[$past(i_mc_rt)] == $past(ashut_ff[i_mc_rt]))
        else $error("mode code acted on with auto off");
    a_auto_on: assert property ((i_mc_strobe &&
        rtcfg_ff[i_mc_rt][tmc_pkg::RTC_AUTO_BIT] &&
        i_mc_code == tmc_pkg::MC_SEL_SHUTDOWN &&
        i_mc_data == sela_ff[i_mc_rt]) |=> ashut_ff[$past(i_mc_rt)][0] ##1
        o_tx_inhibit[2*$past(i_mc_rt, 2)])
        else $error("selected bus not shut down");
    a_active_or: assert property (o_active ==
        $past(i_other_active || (mcfg_ff[1] && i_mt_active)))
        else $error("activity output wrong");
    a_txo_rx: assert property ((mcfg_ff[tmc_pkg::CFG_TXO_BIT] &&
        $stable(mcfg_ff)) |=> o_rx_inhibit == 4'h0)
        else $error("receive inhibited in transmit-only mode");
endmodule

// file: dv/tmc_host_model.sv
// host processor model driving the register port of tmc_top
// assumes strobes are sampled on the rising edge of i_mclk
`timescale 1ns/1ns
module tmc_host_model (
    input wire logic i_mclk,         // system clock
    input wire logic i_ready,        // device ready pin
    input wire logic [15:0] i_rdata, // read data
    output logic o_rd,               // read strobe
    output logic o_wr,               // write strobe
    output logic [15:0] o_addr,      // word address
    output logic [15:0] o_wdata      // write data
);
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end
    // released bus shows the inverse so stale values never match
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 1000 && !ok; n++) begin
            @(posedge i_mclk);
            #1;
            ok = (i_ready === 1'b1);
        end
    endtask
endmodule

// file: dv/tmc_top_test.sv
// self-checking bench of the master control and status block
// assumes the host model above and a 125 MHz clock
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end end
module tmc_top_test;
    logic clk, rst, hrd, hwr, hrv, aie, aib, bb, mtd, mcs, mcr;
    logic ev, ack, mta, oth, irq_n, ready, active, mtreq;
    logic [15:0] haddr, hwd, hrdata, mcd;
    logic [1:0] rtd, rtreq;
    logic [4:0] mcc;
    logic [3:0] txi, rxi;
    int err_total = 0;
    int num_checks = 0;
    tmc_top i_tmc_top (.i_mclk(clk), .i_rst(rst), .i_host_rd(hrd),
        .i_host_wr(hwr), .i_host_addr(haddr), .i_host_wdata(hwd),
        .o_host_rdata(hrdata), .o_host_rvalid(hrv),
        .i_auto_init_enable(aie), .i_auto_init_busy(aib),
        .i_bist_busy(bb), .i_mt_reset_done(mtd), .i_rt_reset_done(rtd),
        .i_mc_strobe(mcs), .i_mc_rt(mcr), .i_mc_code(mcc),
        .i_mc_data(mcd), .i_irq_event(ev),
        .i_interrupt_acknowledge_input(ack), .i_mt_active(mta),
        .i_other_active(oth), .o_irq_n(irq_n), .o_ready(ready),
        .o_active(active), .o_mt_reset_req(mtreq),
        .o_rt_reset_req(rtreq), .o_tx_inhibit(txi), .o_rx_inhibit(rxi));
    tmc_host_model i_tmc_host_model (.i_mclk(clk), .i_ready(ready),
        .i_rdata(hrdata), .o_rd(hrd), .o_wr(hwr), .o_addr(haddr),
        .o_wdata(hwd));
    task w(input logic [15:0] a, input logic [15:0] d);
        i_tmc_host_model.wr(a, d);
    endtask
    task r(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        i_tmc_host_model.rd(a, d);
        `CHK(d, e)
        `CHK(hrv, 1'b1)
    endtask
    task rdy;
        logic ok;
        i_tmc_host_model.wait_ready(ok);
        `CHK(ok, 1'b1)
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task mc(input logic t, input logic [4:0] c, input logic [15:0] dt);
        @(posedge clk);
        mcs <= 1'b1;
        mcr <= t;
        mcc <= c;
        mcd <= dt;
        @(posedge clk);
        mcs <= 1'b0;
        mcd <= ~dt;
        settle(3);
    endtask
    task t_regs;
        rdy();
        r(16'h0001, 16'hA000);
        w(16'h0000, 16'h000F);
        r(16'h0000, 16'h000E);
        r(16'h0100, 16'h0000);
    endtask
    task t_soft;
        w(16'h0001, 16'h1000);
        #1 `CHK({ready, mtreq}, 2'b01)
        w(16'h0000, 16'h0004);
        r(16'h0020, 16'h3000);
        @(posedge clk) mtd <= 1'b1;
        @(posedge clk) mtd <= 1'b0;
        rdy();
        r(16'h0000, 16'h000E);
        w(16'h0001, 16'h0400);
        #1 `CHK({ready, rtreq}, 3'h1)
        @(posedge clk) rtd <= 2'h1;
        @(posedge clk) rtd <= 2'h0;
        rdy();
        r(16'h0001, 16'hA000);
        @(posedge clk) bb <= 1'b1;
        settle(2);
        `CHK(ready, 1'b0)
        r(16'h0000, 16'h2000);
        @(posedge clk) bb <= 1'b0;
        rdy();
    endtask
    task t_pulse;
        int n;
        n = 0;
        w(16'h0000, 16'h0000);
        @(posedge clk) ev <= 1'b1;
        for (int k = 0; k < 140; k++) begin
            @(posedge clk);
            ev <= (k == 50);
            #1;
            n += int'(irq_n === 1'b0);
        end
        `CHK(n, 125)
    endtask
    task t_level;
        w(16'h0000, 16'h0004);
        @(posedge clk) ev <= 1'b1;
        @(posedge clk) ev <= 1'b0;
        settle(200);
        `CHK(irq_n, 1'b0)
        @(posedge clk) ack <= 1'b1;
        settle(20);
        `CHK(irq_n, 1'b0)
        settle(20);
        @(posedge clk) ack <= 1'b0;
        #1 `CHK(irq_n, 1'b1)
        @(posedge clk) ev <= 1'b1;
        @(posedge clk) ev <= 1'b0;
        settle(3);
        `CHK(irq_n, 1'b0)
        r(16'h0006, 16'h0000);
        settle(2);
        `CHK(irq_n, 1'b1)
    endtask
    task t_act;
        w(16'h0000, 16'h0000);
        @(posedge clk) mta <= 1'b1;
        settle(2);
        `CHK(active, 1'b0)
        w(16'h0000, 16'h0002);
        settle(2);
        `CHK(active, 1'b1)
        @(posedge clk) mta <= 1'b0;
        oth <= 1'b1;
        settle(2);
        `CHK(active, 1'b1)
    endtask
    task t_mc;
        w(16'h0010, 16'h0004);
        w(16'h0011, 16'h1234);
        mc(1'b0, 5'h14, 16'h1234);
        `CHK({txi, rxi}, 8'h11)
        r(16'h0010, 16'h0004);
        r(16'h0013, 16'h3000);
        mc(1'b0, 5'h15, 16'h1234);
        `CHK({txi, rxi}, 8'h00)
        w(16'h0000, 16'h0008);
        w(16'h0020, 16'h0002);
        w(16'h0021, 16'h5555);
        mc(1'b1, 5'h14, 16'h5555);
        `CHK({txi, rxi}, 8'h80)
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst, aie} = 2'b11;
        {aib, bb, mtd, mcs, mcr, ev, ack, mta, oth} = 9'h000;
        {rtd, mcc, mcd} = 23'h000000;
        settle(5);
        `CHK({ready, irq_n}, 2'b01)
        @(posedge clk) rst <= 1'b0;
        t_regs();
        t_soft();
        t_pulse();
        t_level();
        t_act();
        t_mc();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule
